// *** cab_exec.sv ***
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Register add, with or without carry, writes sum and sets Z,C,N,V,H in one cycle.
// - Subtract register or constant, with or without borrow, stores difference, Z,C,N,V,H.
// - Word add or subtract of immediate on a pair takes two cycles, sets Z,C,N,V,S.
// - AND, OR, XOR take one cycle, set Z,N,V only, carry and half-carry kept.
// - Set bits ORs the constant; clear bits ANDs with 0xff minus constant.
// - Test ANDs a register with itself, value kept, Z,N,V set in one cycle.
// - Multiplies of three signedness kinds put product in r1:r0, set Z,C, two cycles.
// - Fractional multiplies shift the product left one before storing, Z,C, two cycles.
// - Relative jump and call go to pc plus offset plus one; indirect forms use Z.
// - Compares compute the difference without storing it and set Z,N,V,C,H.
// - Equal compare skips the next instruction, advancing pc by two or three.
// - Register bit skip tests one bit and skips on cleared or set.
// - I/O bit skip tests one I/O bit and skips when it matches.
// - Flag branches add offset plus one when matching: one cycle, two when taken.
// - Signed ge branches when N xor V is 0, signed lt when it is 1.
// - Unsigned same-or-higher branches on carry clear, lower on carry set.
// - Half-carry, T and overflow branches exist in set and cleared forms.
// - I/O bit set and clear reach addresses 0x00 to 0x1f only.
// - I/O bit set and clear rewrite the whole register read before.
module cab_exec
	import cab_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire cab_instr_s cur,
	output logic [PC_W-1:0] pc_q,
	output logic [5:0] io_rd_addr,
	input wire logic [7:0] io_rd_data,
	output logic io_wr_en_q,
	output logic [5:0] io_wr_addr_q,
	output logic [7:0] io_wr_data_q,
	output logic push_en_q,
	output logic [PC_W-1:0] push_addr_q,
	input wire logic [5:0] sw_addr,
	input wire logic [7:0] sw_wdata,
	input wire logic sw_we,
	input wire logic sw_re,
	output logic [7:0] sw_rdata_q
);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	cab_state_e state_q;
	cab_state_e ex_state;
	logic [7:0] gpr_q [GPR_N];
	logic [7:0] status_flags_q;
	logic [7:0] ex_flags;
	logic ex_flag_we;
	logic in_exec;
	logic [7:0] opa;
	logic [7:0] opb;
	logic [7:0] alu_b;
	logic alu_cin;
	logic alu_sub;
	cab_alu_s au;
	logic [15:0] wv;
	logic [16:0] wsum;
	logic [15:0] ea;
	logic [15:0] eb;
	logic [15:0] prod;
	logic [PC_W-1:0] ex_pc;
	logic [PC_W-1:0] br_target;
	logic w0_en;
	logic [4:0] w0_idx;
	logic [7:0] w0_dat;
	logic w1_en;
	logic [4:0] w1_idx;
	logic [7:0] w1_dat;
	logic ex_push;
	logic ex_io_we;
	logic [7:0] ex_io_dat;
	logic [7:0] bit_mask;
	logic br_take;

	function automatic cab_alu_s add8(input logic [7:0] a, input logic [7:0] b,
		input logic cin, input logic sub);
		cab_alu_s r;
		logic [8:0] s;
		logic [4:0] lo;
		if (sub) begin
			s = {1'b0, a} - {1'b0, b} - {8'h00, cin};
			lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
			r.v = (a[7] & ~b[7] & ~s[7]) | (~a[7] & b[7] & s[7]);
		end else begin
			s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
			lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
			r.v = (a[7] & b[7] & ~s[7]) | (~a[7] & ~b[7] & s[7]);
		end
		r.res = s[7:0];
		r.c = s[8];
		r.h = lo[4];
		return r;
	endfunction : add8

	assign in_exec = state_q == ST_EXEC;
	assign opa = gpr_q[cur.rd];
	assign opb = gpr_q[cur.rr];
	assign bit_mask = 8'h01 << cur.sel;
	assign io_rd_addr = {1'b0, cur.rr};
	assign br_target = pc_q + cur.ofs + PC_STEP;

	// Operand selection for the byte adder.
	always_comb begin
		alu_b = opb;
		alu_cin = 1'b0;
		alu_sub = 1'b1;
		unique case (cur.op)
			OP_PLUS: alu_sub = 1'b0;
			OP_PLUS_CARRY: begin
				alu_sub = 1'b0;
				alu_cin = status_flags_q[FLAG_C];
			end
			OP_MINUS_WITH_BORROW, OP_COMPARE_WITH_CARRY: alu_cin = status_flags_q[FLAG_C];
			OP_MINUS_CONSTANT, OP_COMPARE_IMM: alu_b = cur.imm;
			OP_MINUS_CONSTANT_BORROW: begin
				alu_b = cur.imm;
				alu_cin = status_flags_q[FLAG_C];
			end
			default: alu_sub = 1'b1;
		endcase
	end

	assign au = add8(opa, alu_b, alu_cin, alu_sub);

	// Word pair arithmetic and the multiplier.
	always_comb begin
		wv = {gpr_q[5'(cur.rd + 5'h01)], gpr_q[cur.rd]};
		if (cur.op == OP_WORD_MINUS_IMM) begin
			wsum = {1'b0, wv} - {9'h000, cur.imm};
		end else begin
			wsum = {1'b0, wv} + {9'h000, cur.imm};
		end
		ea = {8'h00, opa};
		eb = {8'h00, opb};
		if (cur.op inside {OP_PRODUCT_SIGNED, OP_PRODUCT_MIXED, OP_FRAC_PRODUCT_SIGNED,
			OP_FRAC_PRODUCT_MIXED}) begin
			ea = {{8{opa[7]}}, opa};
		end
		if (cur.op inside {OP_PRODUCT_SIGNED, OP_FRAC_PRODUCT_SIGNED}) begin
			eb = {{8{opb[7]}}, opb};
		end
		prod = ea * eb;
	end

	// Decode and execute of the instruction in front of the core.
	always_comb begin
		ex_state = ST_EXEC;
		ex_pc = pc_q + PC_STEP;
		ex_flags = status_flags_q;
		ex_flag_we = 1'b0;
		w0_en = 1'b0;
		w0_idx = cur.rd;
		w0_dat = au.res;
		w1_en = 1'b0;
		w1_idx = 5'(cur.rd + 5'h01);
		w1_dat = 8'h00;
		ex_push = 1'b0;
		ex_io_we = 1'b0;
		ex_io_dat = io_rd_data;
		br_take = 1'b0;
		unique case (cur.op)
			OP_PLUS, OP_PLUS_CARRY, OP_MINUS, OP_MINUS_WITH_BORROW, OP_MINUS_CONSTANT,
			OP_MINUS_CONSTANT_BORROW, OP_COMPARE_REGS, OP_COMPARE_WITH_CARRY,
			OP_COMPARE_IMM: begin
				w0_en = !(cur.op inside {OP_COMPARE_REGS, OP_COMPARE_WITH_CARRY,
					OP_COMPARE_IMM});
				ex_flag_we = 1'b1;
				ex_flags[FLAG_Z] = au.res == 8'h00;
				ex_flags[FLAG_C] = au.c;
				ex_flags[FLAG_N] = au.res[7];
				ex_flags[FLAG_V] = au.v;
				ex_flags[FLAG_H] = au.h;
			end
			OP_WORD_PLUS_IMM, OP_WORD_MINUS_IMM: begin
				w0_en = 1'b1;
				w0_dat = wsum[7:0];
				w1_en = 1'b1;
				w1_dat = wsum[15:8];
				ex_flag_we = 1'b1;
				ex_flags[FLAG_Z] = wsum[15:0] == 16'h0000;
				ex_flags[FLAG_C] = wsum[16];
				ex_flags[FLAG_N] = wsum[15];
				ex_flags[FLAG_V] = (cur.op == OP_WORD_PLUS_IMM) ? (~wv[15] & wsum[15])
					: (wv[15] & ~wsum[15]);
				ex_flags[FLAG_S] = wsum[15] ^ ex_flags[FLAG_V];
				ex_state = ST_HOLD;
			end
			OP_CONJ_REGS, OP_BITWISE_CONJ_IMM, OP_DISJ_REGS, OP_BITWISE_DISJ_IMM,
			OP_BITWISE_XOR_REGS, OP_SET_BITS_IMM, OP_CLEAR_BITS_IMM, OP_ZERO_SIGN_TEST: begin
				unique case (cur.op)
					OP_CONJ_REGS: w0_dat = opa & opb;
					OP_BITWISE_CONJ_IMM: w0_dat = opa & cur.imm;
					OP_DISJ_REGS: w0_dat = opa | opb;
					OP_BITWISE_DISJ_IMM, OP_SET_BITS_IMM: w0_dat = opa | cur.imm;
					OP_CLEAR_BITS_IMM: w0_dat = opa & (ALL_ONES - cur.imm);
					OP_ZERO_SIGN_TEST: w0_dat = opa & opa;
					default: w0_dat = opa ^ opb;
				endcase
				w0_en = 1'b1;
				ex_flag_we = 1'b1;
				ex_flags[FLAG_Z] = w0_dat == 8'h00;
				ex_flags[FLAG_N] = w0_dat[7];
				ex_flags[FLAG_V] = 1'b0;
			end
			OP_PRODUCT_UNSIGNED, OP_PRODUCT_SIGNED, OP_PRODUCT_MIXED, OP_FRAC_PRODUCT_UNSIGNED,
			OP_FRAC_PRODUCT_SIGNED, OP_FRAC_PRODUCT_MIXED: begin
				w0_en = 1'b1;
				w1_en = 1'b1;
				w0_idx = PROD_LO_IDX;
				w1_idx = PROD_HI_IDX;
				if (cur.op inside {OP_PRODUCT_UNSIGNED, OP_PRODUCT_SIGNED, OP_PRODUCT_MIXED}) begin
					{w1_dat, w0_dat} = prod;
				end else begin
					{w1_dat, w0_dat} = {prod[14:0], 1'b0};
				end
				ex_flag_we = 1'b1;
				ex_flags[FLAG_C] = prod[15];
				ex_flags[FLAG_Z] = {w1_dat, w0_dat} == 16'h0000;
				ex_state = ST_HOLD;
			end
			OP_REL_JUMP: begin
				ex_pc = br_target;
				ex_state = ST_HOLD;
			end
			OP_INDIRECT_JUMP: begin
				ex_pc = PC_W'({gpr_q[PTR_HI_IDX], gpr_q[PTR_LO_IDX]});
				ex_state = ST_HOLD;
			end
			OP_REL_CALL, OP_INDIRECT_CALL: begin
				ex_pc = (cur.op == OP_REL_CALL) ? br_target
					: PC_W'({gpr_q[PTR_HI_IDX], gpr_q[PTR_LO_IDX]});
				ex_push = 1'b1;
				ex_state = ST_CALL;
			end
			OP_EQUAL_SKIP: ex_state = (opa == opb) ? ST_SKIP : ST_EXEC;
			OP_SKIP_REG_BIT_CLEAR: ex_state = opb[cur.sel] ? ST_EXEC : ST_SKIP;
			OP_SKIP_REG_BIT_SET: ex_state = opb[cur.sel] ? ST_SKIP : ST_EXEC;
			OP_SKIP_IO_BIT_CLEAR: ex_state = io_rd_data[cur.sel] ? ST_EXEC : ST_SKIP;
			OP_SKIP_IO_BIT_SET: ex_state = io_rd_data[cur.sel] ? ST_SKIP : ST_EXEC;
			OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR, OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT,
			OP_BRANCH_UNSIGNED_HS, OP_BRANCH_UNSIGNED_LO, OP_BRANCH_HALFCARRY_SET,
			OP_BRANCH_HALFCARRY_CLEAR, OP_BRANCH_TBIT_SET, OP_BRANCH_TBIT_CLEAR,
			OP_BRANCH_OVF_SET, OP_BRANCH_OVF_CLEAR: begin
				unique case (cur.op)
					OP_BRANCH_FLAG_SET: br_take = status_flags_q[cur.sel];
					OP_BRANCH_FLAG_CLEAR: br_take = !status_flags_q[cur.sel];
					OP_BRANCH_SIGNED_GE: br_take = (status_flags_q[FLAG_N]
						^ status_flags_q[FLAG_V]) == 1'b0;
					OP_BRANCH_SIGNED_LT: br_take = (status_flags_q[FLAG_N]
						^ status_flags_q[FLAG_V]) == 1'b1;
					OP_BRANCH_UNSIGNED_HS: br_take = !status_flags_q[FLAG_C];
					OP_BRANCH_UNSIGNED_LO: br_take = status_flags_q[FLAG_C];
					OP_BRANCH_HALFCARRY_SET: br_take = status_flags_q[FLAG_H];
					OP_BRANCH_HALFCARRY_CLEAR: br_take = !status_flags_q[FLAG_H];
					OP_BRANCH_TBIT_SET: br_take = status_flags_q[FLAG_T];
					OP_BRANCH_TBIT_CLEAR: br_take = !status_flags_q[FLAG_T];
					OP_BRANCH_OVF_SET: br_take = status_flags_q[FLAG_V];
					default: br_take = !status_flags_q[FLAG_V];
				endcase
				if (br_take) begin
					ex_pc = br_target;
					ex_state = ST_HOLD;
				end
			end
			OP_IO_BIT_SET, OP_IO_BIT_CLEAR: begin
				ex_io_we = 1'b1;
				ex_io_dat = (cur.op == OP_IO_BIT_SET) ? (io_rd_data | bit_mask)
					: (io_rd_data & ~bit_mask);
				ex_state = ST_HOLD;
			end
			default: ex_state = ST_EXEC;
		endcase
	end

	// Sequencer: extra cycles of multi-cycle instructions and of skips.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_EXEC;
		end else begin
			unique case (state_q)
				ST_EXEC: state_q <= ex_state;
				ST_CALL: state_q <= ST_HOLD;
				ST_SKIP: state_q <= cur.two_word ? ST_SKIP2 : ST_EXEC;
				default: state_q <= ST_EXEC;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pc_q <= PC_RST;
		end else if (in_exec) begin
			pc_q <= ex_pc;
		end else if (state_q == ST_SKIP) begin
			pc_q <= pc_q + (cur.two_word ? PC_STEP2 : PC_STEP);
		end
	end

	sequence call_tail_s;
		state_q == ST_CALL ##1 state_q == ST_HOLD ##1 state_q == ST_EXEC;
	endsequence

	sequence skip_long_s;
		state_q == ST_SKIP ##1 state_q == ST_SKIP2 ##1 state_q == ST_EXEC;
	endsequence

	call_three_cycles_a: assert property (
		in_exec && cur.op == OP_REL_CALL |=> pc_q == $past(br_target) ##0 call_tail_s)
		else $error("relative call does not last three cycles or misses its target");

	skip_two_word_a: assert property (
		state_q == ST_SKIP && cur.two_word |-> skip_long_s ##0 pc_q == $past(pc_q, 2) + PC_STEP2)
		else $error("skip over a two-word instruction is not three cycles");

	equal_skip_a: assert property (
		in_exec && cur.op == OP_EQUAL_SKIP && opa == opb |=> state_q == ST_SKIP)
		else $error("equal compare did not start a skip");

	branch_not_taken_a: assert property (
		in_exec && cur.op == OP_BRANCH_SIGNED_GE && !br_take
		|=> state_q == ST_EXEC && pc_q == $past(pc_q) + PC_STEP)
		else $error("untaken branch did not fall through in one cycle");

	signed_ge_target_a: assert property (
		in_exec && cur.op == OP_BRANCH_SIGNED_GE
		&& (status_flags_q[FLAG_N] == status_flags_q[FLAG_V])
		|=> pc_q == $past(br_target) ##1 in_exec)
		else $error("signed ge branch not taken with N equal to V");

	unsigned_lo_a: assert property (
		in_exec && cur.op == OP_BRANCH_UNSIGNED_LO && !status_flags_q[FLAG_C]
		|=> pc_q == $past(pc_q) + PC_STEP)
		else $error("unsigned lower branch taken with carry clear");

	// Working registers; core writes win over a software write in the same cycle.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < GPR_N; i++) begin
				gpr_q[i] <= GPR_RST;
			end
		end else begin
			if (sw_we && sw_addr <= SW_GPR_LAST) begin
				gpr_q[sw_addr[4:0]] <= sw_wdata;
			end
			if (in_exec && w0_en) begin
				gpr_q[w0_idx] <= w0_dat;
			end
			if (in_exec && w1_en) begin
				gpr_q[w1_idx] <= w1_dat;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			status_flags_q <= STATUS_RST;
		end else if (in_exec && ex_flag_we) begin
			status_flags_q <= ex_flags;
		end else if (sw_we && sw_addr == SW_STATUS_ADDR) begin
			status_flags_q <= sw_wdata;
		end
	end

	plus_result_a: assert property (
		in_exec && cur.op == OP_PLUS && cur.rd != cur.rr
		|=> gpr_q[$past(cur.rd)] == $past(8'(opa + opb)) && $past(ex_state) == ST_EXEC)
		else $error("register add result wrong");

	logic_keeps_carry_a: assert property (
		in_exec && cur.op == OP_BITWISE_XOR_REGS
		|=> status_flags_q[FLAG_C] == $past(status_flags_q[FLAG_C])
		&& status_flags_q[FLAG_H] == $past(status_flags_q[FLAG_H]) && !status_flags_q[FLAG_V])
		else $error("logic operation disturbed carry or half-carry");

	compare_no_store_a: assert property (
		in_exec && cur.op == OP_COMPARE_REGS && !sw_we
		|=> gpr_q[$past(cur.rd)] == $past(opa)
		&& status_flags_q[FLAG_Z] == ($past(opa) == $past(opb)))
		else $error("compare stored a result or set Z wrongly");

	word_two_cycles_a: assert property (
		in_exec && cur.op == OP_WORD_PLUS_IMM |=> state_q == ST_HOLD ##1 in_exec)
		else $error("word add does not take two cycles");

	frac_product_a: assert property (
		in_exec && cur.op == OP_FRAC_PRODUCT_UNSIGNED
		|=> {gpr_q[PROD_HI_IDX], gpr_q[PROD_LO_IDX]} == {$past(prod[14:0]), 1'b0})
		else $error("fractional product not shifted into r1:r0");

	product_pair_a: assert property (
		in_exec && cur.op == OP_PRODUCT_SIGNED
		|=> {gpr_q[PROD_HI_IDX], gpr_q[PROD_LO_IDX]} == $past(prod)
		&& status_flags_q[FLAG_C] == $past(prod[15]))
		else $error("signed product not placed in r1:r0");

	// I/O write-back of bit operations and the return address push.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			io_wr_en_q <= 1'b0;
			io_wr_addr_q <= 6'h00;
			io_wr_data_q <= 8'h00;
		end else begin
			io_wr_en_q <= in_exec && ex_io_we;
			if (in_exec && ex_io_we) begin
				io_wr_addr_q <= io_rd_addr & IO_BITOP_LAST;
				io_wr_data_q <= ex_io_dat;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			push_en_q <= 1'b0;
			push_addr_q <= PC_RST;
		end else begin
			push_en_q <= in_exec && ex_push;
			if (in_exec && ex_push) begin
				push_addr_q <= pc_q + PC_STEP;
			end
		end
	end

	io_bit_rmw_a: assert property (
		in_exec && cur.op == OP_IO_BIT_SET
		|=> io_wr_en_q && io_wr_data_q == ($past(io_rd_data) | $past(bit_mask)) ##1 !io_wr_en_q)
		else $error("I/O bit set is not a whole-register write-back");

	io_range_a: assert property (
		io_wr_en_q |-> io_wr_addr_q <= IO_BITOP_LAST && state_q == ST_HOLD)
		else $error("I/O bit operation outside the low I/O range");

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sw_rdata_q <= 8'h00;
		end else if (sw_re) begin
			if (sw_addr <= SW_GPR_LAST) begin
				sw_rdata_q <= gpr_q[sw_addr[4:0]];
			end else if (sw_addr == SW_STATUS_ADDR) begin
				sw_rdata_q <= status_flags_q;
			end else begin
				sw_rdata_q <= 8'h00;
			end
		end
	end

endmodule : cab_exec

`default_nettype wire

// *** cab_pkg.sv ***
package cab_pkg;

	localparam int unsigned PC_W = 12;
	localparam int unsigned GPR_N = 32;

	localparam logic [2:0] FLAG_C = 3'h0;
	localparam logic [2:0] FLAG_Z = 3'h1;
	localparam logic [2:0] FLAG_N = 3'h2;
	localparam logic [2:0] FLAG_V = 3'h3;
	localparam logic [2:0] FLAG_S = 3'h4;
	localparam logic [2:0] FLAG_H = 3'h5;
	localparam logic [2:0] FLAG_T = 3'h6;

	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] GPR_RST = 8'h00;
	localparam logic [11:0] PC_RST = 12'h000;
	localparam logic [11:0] PC_STEP = 12'h001;
	localparam logic [11:0] PC_STEP2 = 12'h002;
	localparam logic [7:0] ALL_ONES = 8'hff;

	localparam logic [5:0] SW_GPR_LAST = 6'h1f;
	localparam logic [5:0] SW_STATUS_ADDR = 6'h20;
	localparam logic [5:0] IO_BITOP_LAST = 6'h1f;

	localparam logic [4:0] PTR_LO_IDX = 5'h1e;
	localparam logic [4:0] PTR_HI_IDX = 5'h1f;
	localparam logic [4:0] PROD_LO_IDX = 5'h00;
	localparam logic [4:0] PROD_HI_IDX = 5'h01;

	typedef enum logic [5:0] {
		OP_NOP, OP_PLUS, OP_PLUS_CARRY, OP_MINUS, OP_MINUS_WITH_BORROW, OP_MINUS_CONSTANT,
		OP_MINUS_CONSTANT_BORROW, OP_WORD_PLUS_IMM, OP_WORD_MINUS_IMM, OP_CONJ_REGS,
		OP_BITWISE_CONJ_IMM, OP_DISJ_REGS, OP_BITWISE_DISJ_IMM, OP_BITWISE_XOR_REGS,
		OP_SET_BITS_IMM, OP_CLEAR_BITS_IMM, OP_ZERO_SIGN_TEST, OP_PRODUCT_UNSIGNED,
		OP_PRODUCT_SIGNED, OP_PRODUCT_MIXED, OP_FRAC_PRODUCT_UNSIGNED, OP_FRAC_PRODUCT_SIGNED,
		OP_FRAC_PRODUCT_MIXED, OP_REL_JUMP, OP_INDIRECT_JUMP, OP_REL_CALL, OP_INDIRECT_CALL,
		OP_EQUAL_SKIP, OP_COMPARE_REGS, OP_COMPARE_WITH_CARRY, OP_COMPARE_IMM,
		OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET, OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET,
		OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR, OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT,
		OP_BRANCH_UNSIGNED_HS, OP_BRANCH_UNSIGNED_LO, OP_BRANCH_HALFCARRY_SET,
		OP_BRANCH_HALFCARRY_CLEAR, OP_BRANCH_TBIT_SET, OP_BRANCH_TBIT_CLEAR,
		OP_BRANCH_OVF_SET, OP_BRANCH_OVF_CLEAR, OP_IO_BIT_CLEAR, OP_IO_BIT_SET
	} cab_op_e;

	typedef enum logic [2:0] {
		ST_EXEC = 3'b000,
		ST_HOLD = 3'b001,
		ST_CALL = 3'b011,
		ST_SKIP = 3'b010,
		ST_SKIP2 = 3'b110
	} cab_state_e;

	typedef struct packed {
		cab_op_e op;
		logic [4:0] rd;
		logic [4:0] rr;
		logic [7:0] imm;
		logic [2:0] sel;
		logic [PC_W-1:0] ofs;
		logic two_word;
	} cab_instr_s;

	typedef struct packed {
		logic [7:0] res;
		logic c;
		logic h;
		logic v;
	} cab_alu_s;

endpackage : cab_pkg

// *** cab_prog_mem.sv ***
`timescale 1ns/1ps
`default_nettype none

module cab_prog_mem
	import cab_pkg::*;
(
	input wire logic clk,
	input wire logic [PC_W-1:0] pc,
	output cab_instr_s cur,
	input wire logic [5:0] io_rd_addr,
	output logic [7:0] io_rd_data,
	input wire logic io_wr_en,
	input wire logic [5:0] io_wr_addr,
	input wire logic [7:0] io_wr_data
);
	cab_instr_s mem [64];
	logic [7:0] io_q [64];

	// Instruction words and I/O data are presented in the same cycle as their address.
	assign cur = mem[pc[5:0]];
	assign io_rd_data = io_q[io_rd_addr];

	// Bit zero of each I/O register is a flag cleared by writing one; other bits store.
	always @(posedge clk) begin
		if (io_wr_en) begin
			io_q[io_wr_addr] <= (io_q[io_wr_addr] & ~io_wr_data & 8'h01)
				| (io_wr_data & 8'hfe);
		end
	end
endmodule : cab_prog_mem

`default_nettype wire

// *** test_cpu_alu_branch_exec.sv ***
`timescale 1ns/1ps
`default_nettype none

module test_cpu_alu_branch_exec
	import cab_pkg::*;
;
	typedef struct {cab_op_e op; logic [7:0] a, b, k, s, ea, eb, so; int cyc;} cab_alu_row_s;
	typedef struct {cab_op_e op; logic [7:0] a; logic [4:0] rr; logic [2:0] sel;
		logic [7:0] s, iov; logic tw, t; int e;} cab_flow_row_s;
	logic clk;
	logic rst;
	logic sw_we;
	logic sw_re;
	logic io_wr_en_q;
	logic push_en_q;
	logic [5:0] sw_addr, io_rd_addr, io_wr_addr_q;
	logic [7:0] sw_wdata, sw_rdata_q, io_rd_data, io_wr_data_q;
	logic [PC_W-1:0] pc_q, push_addr_q;
	cab_instr_s cur;
	logic [5:0] wa [$];
	logic [7:0] wd [$];
	int err_count = 0;
	int checks_done = 0;
	int cyc_n = 0;
	int push_n = 0;
	int iow_n = 0;
	cab_alu_row_s alu_tab [25] = '{
		'{OP_PLUS,8'h0f,8'h01,8'h00,8'h00,8'h10,8'h01,8'h20,1},
		'{OP_PLUS_CARRY,8'h7f,8'h00,8'h00,8'h01,8'h80,8'h00,8'h2c,1},
		'{OP_MINUS,8'h00,8'h01,8'h00,8'h00,8'hff,8'h01,8'h25,1},
		'{OP_MINUS_WITH_BORROW,8'h80,8'h00,8'h00,8'h01,8'h7f,8'h00,8'h28,1},
		'{OP_MINUS_CONSTANT,8'h05,8'h00,8'h05,8'h40,8'h00,8'h00,8'h42,1},
		'{OP_MINUS_CONSTANT_BORROW,8'h10,8'h00,8'h00,8'h01,8'h0f,8'h00,8'h20,1},
		'{OP_CONJ_REGS,8'hf0,8'h8f,8'h00,8'h29,8'h80,8'h8f,8'h25,1},
		'{OP_BITWISE_CONJ_IMM,8'h0f,8'h00,8'hf0,8'h00,8'h00,8'h00,8'h02,1},
		'{OP_DISJ_REGS,8'h01,8'h80,8'h00,8'h00,8'h81,8'h80,8'h04,1},
		'{OP_BITWISE_DISJ_IMM,8'h00,8'h00,8'h00,8'h0c,8'h00,8'h00,8'h02,1},
		'{OP_BITWISE_XOR_REGS,8'haa,8'haa,8'h00,8'h01,8'h00,8'haa,8'h03,1},
		'{OP_SET_BITS_IMM,8'h01,8'h00,8'h80,8'h00,8'h81,8'h00,8'h04,1},
		'{OP_CLEAR_BITS_IMM,8'hff,8'h00,8'h0f,8'h00,8'hf0,8'h00,8'h04,1},
		'{OP_ZERO_SIGN_TEST,8'h80,8'h00,8'h00,8'h00,8'h80,8'h00,8'h04,1},
		'{OP_COMPARE_REGS,8'h10,8'h20,8'h00,8'h00,8'h10,8'h20,8'h05,1},
		'{OP_COMPARE_WITH_CARRY,8'h01,8'h00,8'h00,8'h03,8'h01,8'h00,8'h02,1},
		'{OP_COMPARE_IMM,8'h80,8'h00,8'h01,8'h00,8'h80,8'h00,8'h28,1},
		'{OP_WORD_PLUS_IMM,8'hff,8'h7f,8'h01,8'h10,8'h00,8'h80,8'h0c,2},
		'{OP_WORD_MINUS_IMM,8'h00,8'h00,8'h01,8'h00,8'hff,8'hff,8'h15,2},
		'{OP_PRODUCT_UNSIGNED,8'hff,8'hff,8'h00,8'h00,8'h01,8'hfe,8'h01,2},
		'{OP_PRODUCT_SIGNED,8'hff,8'h01,8'h00,8'h00,8'hff,8'hff,8'h01,2},
		'{OP_PRODUCT_MIXED,8'hff,8'hff,8'h00,8'h00,8'h01,8'hff,8'h01,2},
		'{OP_FRAC_PRODUCT_UNSIGNED,8'h80,8'h80,8'h00,8'h01,8'h00,8'h80,8'h00,2},
		'{OP_FRAC_PRODUCT_SIGNED,8'hc0,8'h40,8'h00,8'h00,8'h00,8'he0,8'h01,2},
		'{OP_FRAC_PRODUCT_MIXED,8'h00,8'h55,8'h00,8'h00,8'h00,8'h00,8'h02,2}};
	cab_flow_row_s flow_tab [33] = '{
		'{OP_BRANCH_FLAG_SET,8'h00,5'h10,3'h1,8'h02,8'h00,1'b0,1'b1,17},
		'{OP_BRANCH_FLAG_SET,8'h00,5'h10,3'h1,8'h00,8'h00,1'b0,1'b0,20},
		'{OP_BRANCH_FLAG_CLEAR,8'h00,5'h10,3'h0,8'h01,8'h00,1'b0,1'b0,20},
		'{OP_BRANCH_FLAG_CLEAR,8'h00,5'h10,3'h6,8'h00,8'h00,1'b0,1'b1,17},
		'{OP_BRANCH_SIGNED_GE,8'h00,5'h10,3'h0,8'h0c,8'h00,1'b0,1'b1,17},
		'{OP_BRANCH_SIGNED_GE,8'h00,5'h10,3'h0,8'h04,8'h00,1'b0,1'b0,20},
		'{OP_BRANCH_SIGNED_LT,8'h00,5'h10,3'h0,8'h08,8'h00,1'b0,1'b1,17},
		'{OP_BRANCH_SIGNED_LT,8'h00,5'h10,3'h0,8'h0c,8'h00,1'b0,1'b0,20},
		'{OP_BRANCH_UNSIGNED_HS,8'h00,5'h10,3'h0,8'h00,8'h00,1'b0,1'b1,17},
		'{OP_BRANCH_UNSIGNED_HS,8'h00,5'h10,3'h0,8'h01,8'h00,1'b0,1'b0,20},
		'{OP_BRANCH_UNSIGNED_LO,8'h00,5'h10,3'h0,8'h01,8'h00,1'b0,1'b1,17},
		'{OP_BRANCH_UNSIGNED_LO,8'h00,5'h10,3'h0,8'h00,8'h00,1'b0,1'b0,20},
		'{OP_BRANCH_HALFCARRY_SET,8'h00,5'h10,3'h0,8'h20,8'h00,1'b0,1'b1,17},
		'{OP_BRANCH_HALFCARRY_CLEAR,8'h00,5'h10,3'h0,8'h20,8'h00,1'b0,1'b0,20},
		'{OP_BRANCH_TBIT_SET,8'h00,5'h10,3'h0,8'h40,8'h00,1'b0,1'b1,17},
		'{OP_BRANCH_TBIT_CLEAR,8'h00,5'h10,3'h0,8'h00,8'h00,1'b0,1'b1,17},
		'{OP_BRANCH_OVF_SET,8'h00,5'h10,3'h0,8'h08,8'h00,1'b0,1'b1,17},
		'{OP_BRANCH_OVF_CLEAR,8'h00,5'h10,3'h0,8'h08,8'h00,1'b0,1'b0,20},
		'{OP_EQUAL_SKIP,8'h5a,5'h11,3'h0,8'h00,8'h00,1'b0,1'b1,20},
		'{OP_EQUAL_SKIP,8'h5b,5'h11,3'h0,8'h00,8'h00,1'b0,1'b0,20},
		'{OP_EQUAL_SKIP,8'h5a,5'h11,3'h0,8'h00,8'h00,1'b1,1'b1,20},
		'{OP_SKIP_REG_BIT_CLEAR,8'h00,5'h10,3'h3,8'h00,8'h00,1'b0,1'b1,20},
		'{OP_SKIP_REG_BIT_CLEAR,8'h08,5'h10,3'h3,8'h00,8'h00,1'b0,1'b0,20},
		'{OP_SKIP_REG_BIT_SET,8'h08,5'h10,3'h3,8'h00,8'h00,1'b1,1'b1,20},
		'{OP_SKIP_IO_BIT_CLEAR,8'h00,5'h10,3'h3,8'h00,8'h00,1'b0,1'b1,20},
		'{OP_SKIP_IO_BIT_SET,8'h00,5'h10,3'h3,8'h00,8'h08,1'b1,1'b1,20},
		'{OP_SKIP_IO_BIT_SET,8'h00,5'h10,3'h3,8'h00,8'h00,1'b0,1'b0,20},
		'{OP_REL_JUMP,8'h00,5'h10,3'h0,8'h00,8'h00,1'b0,1'b1,17},
		'{OP_REL_CALL,8'h00,5'h10,3'h0,8'h00,8'h00,1'b0,1'b1,18},
		'{OP_INDIRECT_JUMP,8'h00,5'h10,3'h0,8'h00,8'h00,1'b0,1'b1,17},
		'{OP_INDIRECT_CALL,8'h00,5'h10,3'h0,8'h00,8'h00,1'b0,1'b1,18},
		'{OP_IO_BIT_SET,8'h00,5'h1f,3'h4,8'h00,8'h01,1'b0,1'b0,21},
		'{OP_IO_BIT_CLEAR,8'h00,5'h1f,3'h4,8'h00,8'h11,1'b0,1'b0,21}};

	cab_exec DUT (.clk(clk), .rst(rst), .cur(cur), .pc_q(pc_q), .io_rd_addr(io_rd_addr),
		.io_rd_data(io_rd_data), .io_wr_en_q(io_wr_en_q), .io_wr_addr_q(io_wr_addr_q),
		.io_wr_data_q(io_wr_data_q), .push_en_q(push_en_q), .push_addr_q(push_addr_q),
		.sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_we(sw_we), .sw_re(sw_re),
		.sw_rdata_q(sw_rdata_q));
	cab_prog_mem PM (.clk(clk), .pc(pc_q), .cur(cur), .io_rd_addr(io_rd_addr),
		.io_rd_data(io_rd_data), .io_wr_en(io_wr_en_q), .io_wr_addr(io_wr_addr_q),
		.io_wr_data(io_wr_data_q));

	task automatic finish_test();
		if (err_count == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : finish_test

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		sw_re <= 1'b1;
		sw_addr <= a;
		@(posedge clk);
		sw_re <= 1'b0;
		@(posedge clk);
		check({8'h00, sw_rdata_q}, {8'h00, e});
	endtask : rd

	task automatic prep();
		rst <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 64; i++) PM.mem[i] = '0;
	endtask : prep

	// Releases reset, presets registers from the queues, counts edges until pc reaches stop.
	task automatic launch(input logic [PC_W-1:0] stop, input int exp_e);
		int n;
		PM.mem[stop[5:0]] = '{OP_REL_JUMP, 5'h00, 5'h00, 8'h00, 3'h0, 12'hfff, 1'b0};
		@(posedge clk);
		rst <= 1'b0;
		for (n = 0; n < 100; n++) begin
			if (n < wa.size()) begin
				sw_we <= 1'b1;
				sw_addr <= wa[n];
				sw_wdata <= wd[n];
			end else begin
				sw_we <= 1'b0;
			end
			@(posedge clk);
			if (pc_q === stop) break;
		end
		check(16'(n), 16'(exp_e));
	endtask : launch

	task automatic alu_run(input cab_alu_row_s r);
		logic [5:0] lo;
		lo = (r.op >= OP_PRODUCT_UNSIGNED && r.op <= OP_FRAC_PRODUCT_MIXED) ? 6'h00 : 6'h10;
		prep();
		PM.mem[8] = '{r.op, 5'h10, 5'h11, r.k, 3'h0, 12'h000, 1'b0};
		wa = '{6'h10, 6'h11, SW_STATUS_ADDR};
		wd = '{r.a, r.b, r.s};
		launch(12'h00a, 9 + r.cyc);
		rd(lo, r.ea);
		rd(lo + 6'h01, r.eb);
		rd(SW_STATUS_ADDR, r.so);
	endtask : alu_run

	task automatic flow_run(input cab_flow_row_s r);
		logic [7:0] m;
		logic [7:0] w;
		logic cl;
		logic io;
		int p0;
		int i0;
		m = 8'h01 << r.sel;
		w = (r.op == OP_IO_BIT_SET) ? (r.iov | m) : (r.iov & ~m);
		cl = r.op == OP_REL_CALL || r.op == OP_INDIRECT_CALL;
		io = r.op == OP_IO_BIT_SET || r.op == OP_IO_BIT_CLEAR;
		prep();
		PM.mem[8] = '{r.op, 5'h10, r.rr, 8'h00, r.sel, 12'h004, 1'b0};
		PM.mem[9] = '{OP_MINUS_CONSTANT, 5'h14, 5'h00, 8'h01, 3'h0, 12'h000, r.tw};
		if (r.tw) PM.mem[10] = '{OP_MINUS_CONSTANT, 5'h14, 5'h00, 8'h02, 3'h0, 12'h000, 1'b0};
		PM.io_q[r.rr] = r.iov;
		wa = '{6'h10, 6'h11, 6'h1e, SW_STATUS_ADDR};
		wd = '{r.a, 8'h5a, 8'h0d, r.s};
		p0 = push_n;
		i0 = iow_n;
		launch(12'h014, r.e);
		rd(6'h14, r.t ? 8'h00 : 8'hff);
		check(16'(push_n - p0), {15'h0000, cl});
		check(16'(iow_n - i0), {15'h0000, io});
		if (cl) begin
			check({4'h0, push_addr_q}, 16'h0009);
		end
		if (io) begin
			check({10'h000, io_wr_addr_q}, 16'h001f);
			check({8'h00, io_wr_data_q}, {8'h00, w});
			check({8'h00, PM.io_q[r.rr]}, {8'h00, w & 8'hfe});
		end
	endtask : flow_run

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc_n <= cyc_n + 1;
		if (push_en_q === 1'b1) push_n <= push_n + 1;
		if (io_wr_en_q === 1'b1) iow_n <= iow_n + 1;
		if (cyc_n == 20000) begin
			err_count++;
			finish_test();
		end
	end

	initial begin
		rst = 1'b1;
		sw_we = 1'b0;
		sw_re = 1'b0;
		sw_addr = 6'h00;
		sw_wdata = 8'h00;
		repeat (8) @(posedge clk);
		foreach (alu_tab[i]) alu_run(alu_tab[i]);
		foreach (flow_tab[i]) flow_run(flow_tab[i]);
		rd(6'h21, 8'h00);
		finish_test();
	end
endmodule : test_cpu_alu_branch_exec

`default_nettype wire
